// file: gas_ctrl_pkg.sv
// Shared constants for the gas sensor mode, measurement and zero-point controller.
package gas_ctrl_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ        = 200_000_000;
	localparam int BAUD_BPS      = 9600;
	localparam int BAUD_DIV      = CLK_HZ / BAUD_BPS;
	localparam int MEAS_PER_SEC  = 2;
	localparam int MEAS_PERIOD   = CLK_HZ / MEAS_PER_SEC;
	localparam int RESP_DELAY_MS = 10;
	localparam int MEAS_BUSY     = (CLK_HZ / 1000) * RESP_DELAY_MS;

	// ----------------------------------------------------------------
	// Operating modes, numbered as the host selects them
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_CMD    = 2'h0;
	localparam logic [1:0] MODE_STREAM = 2'h1;
	localparam logic [1:0] MODE_POLL   = 2'h2;

	// ----------------------------------------------------------------
	// Characters of the command protocol
	// ----------------------------------------------------------------
	localparam logic [7:0] ASC_SP   = 8'h20;
	localparam logic [7:0] ASC_CR   = 8'h0D;
	localparam logic [7:0] ASC_LF   = 8'h0A;
	localparam logic [7:0] ASC_QM   = 8'h3F;
	localparam logic [7:0] ASC_ZERO = 8'h30;
	localparam logic [7:0] CMD_MODE = 8'h4B;
	localparam logic [7:0] CMD_FILT = 8'h41;
	localparam logic [7:0] CMD_RDF  = 8'h5A;
	localparam logic [7:0] CMD_RDR  = 8'h7A;
	localparam logic [7:0] CMD_REF  = 8'h58;
	localparam logic [7:0] CMD_ZKG  = 8'h47;
	localparam logic [7:0] CMD_ZN2  = 8'h55;

	// ----------------------------------------------------------------
	// Register map, field positions and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  REG_STATUS  = 8'h00;
	localparam logic [7:0]  REG_FILT    = 8'h04;
	localparam logic [7:0]  REG_RAW     = 8'h08;
	localparam logic [7:0]  REG_ZERO    = 8'h0C;
	localparam logic [7:0]  REG_CTRL    = 8'h10;
	localparam int          ST_MODE_LSB = 0;
	localparam int          ST_READY    = 2;
	localparam int          ST_BUSY     = 3;
	localparam int          ST_PEND     = 4;
	localparam int          CTRL_FILT_W = 3;
	localparam logic [2:0]  FILT_RST    = 3'h4;
	localparam logic [2:0]  FILT_MAX    = 3'h7;
	localparam logic [15:0] REF_RST     = 16'h0000;

endpackage

// file: gas_uart.sv
// Fixed-rate 8N1 serial receiver and transmitter for the host link.
module gas_uart
	import gas_ctrl_pkg::*;
#(
	parameter int DIV = BAUD_DIV
)(
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_rxd,
	output logic            o_txd,
	output logic            o_rx_valid,
	output logic [7:0]      o_rx_data,
	input  wire logic       i_tx_valid,
	input  wire logic [7:0] i_tx_data,
	output logic            o_tx_ready
);
	localparam int CW = $clog2(DIV + 1);

	if (DIV < 16)
	begin
		$error("baud divisor too small");
	end

	logic          rx_m_q, rx_s_q;
	logic          rx_busy_q;
	logic [3:0]    rx_bit_q;
	logic [CW-1:0] rx_cnt_q;
	logic [7:0]    rx_sh_q;
	logic          tx_busy_q;
	logic [3:0]    tx_bit_q;
	logic [CW-1:0] tx_cnt_q;
	logic [8:0]    tx_sh_q;

	// ----------------------------------------------------------------
	// Receive path
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			rx_m_q <= 1'b1;
			rx_s_q <= 1'b1;
		end
		else
		begin
			rx_m_q <= i_rxd;
			rx_s_q <= rx_m_q;
		end
	end

	// A start bit is confirmed at mid-bit so a glitch on the idle line is dropped.
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			rx_busy_q  <= 1'b0;
			rx_bit_q   <= 4'h0;
			rx_cnt_q   <= '0;
			rx_sh_q    <= 8'h00;
			o_rx_valid <= 1'b0;
			o_rx_data  <= 8'h00;
		end
		else
		begin
			o_rx_valid <= 1'b0;
			if (!rx_busy_q)
			begin
				if (!rx_s_q)
				begin
					rx_busy_q <= 1'b1;
					rx_cnt_q  <= CW'(DIV / 2);
					rx_bit_q  <= 4'h0;
				end
			end
			else if (rx_cnt_q != '0)
				rx_cnt_q <= rx_cnt_q - CW'(1);
			else
			begin
				rx_cnt_q <= CW'(DIV - 1);
				rx_bit_q <= rx_bit_q + 4'h1;
				if (rx_bit_q == 4'h0)
				begin
					if (rx_s_q)
						rx_busy_q <= 1'b0;
				end
				else if (rx_bit_q == 4'h9)
				begin
					rx_busy_q <= 1'b0;
					if (rx_s_q)
					begin
						o_rx_valid <= 1'b1;
						o_rx_data  <= rx_sh_q;
					end
				end
				else
					rx_sh_q <= {rx_s_q, rx_sh_q[7:1]};
			end
		end
	end

	// ----------------------------------------------------------------
	// Transmit path
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			tx_busy_q  <= 1'b0;
			tx_bit_q   <= 4'h0;
			tx_cnt_q   <= '0;
			tx_sh_q    <= 9'h1FF;
			o_txd      <= 1'b1;
			o_tx_ready <= 1'b1;
		end
		else if (!tx_busy_q)
		begin
			if (i_tx_valid && o_tx_ready)
			begin
				tx_busy_q  <= 1'b1;
				o_tx_ready <= 1'b0;
				o_txd      <= 1'b0;
				tx_sh_q    <= {1'b1, i_tx_data};
				tx_bit_q   <= 4'h9;
				tx_cnt_q   <= CW'(DIV - 1);
			end
		end
		else if (tx_cnt_q != '0)
			tx_cnt_q <= tx_cnt_q - CW'(1);
		else if (tx_bit_q == 4'h0)
		begin
			tx_busy_q  <= 1'b0;
			o_tx_ready <= 1'b1;
		end
		else
		begin
			o_txd    <= tx_sh_q[0];
			tx_sh_q  <= {1'b1, tx_sh_q[8:1]};
			tx_bit_q <= tx_bit_q - 4'h1;
			tx_cnt_q <= CW'(DIV - 1);
		end
	end

endmodule

// file: gas_ctrl.sv
// Gas sensor mode, measurement, filter and zero-point controller with serial host link.
// Summary of operation
// [R1] Measuring starts by itself after reset, in streaming settings, without a host command.
// [R2] Measurements complete at a fixed cadence of two per second.
// [R3] Faster requests are answered with the last completed measurement.
// [R4] Exactly three modes: command (0), streaming (1), polling (2).
// [R5] Command mode makes no measurements and only handles host commands.
// [R6] Command mode refuses reading and zero-point commands.
// [R7] Command mode answers commands without measurement deferral.
// [R8] Command mode is never restored after power returns.
// [R9] Streaming mode sends a report after every measurement, twice a second.
// [R10] Streaming mode defers commands during measurement activity, at most 10 ms.
// [R11] Polling mode keeps measuring but only reports on request.
// [R12] Power-up restores whichever of streaming or polling was stored.
// [R13] Host-adjustable low-pass filter setting applies to the sampled reading.
// [R14] A larger filter setting makes the filtered reading settle more slowly.
// [R15] The raw unfiltered reading is also available to the host.
// [R16] Each zeroing replaces the stored zero point; nothing accumulates.
// [R17] Host writes the reference ppm before starting known-gas zeroing.
// [R18] Nitrogen zeroing assumes the present concentration is zero ppm.
// [R19] Host waits for the ready indication before any zeroing command.
// [R20] Link is 9600 bit/s, 8 data bits, no parity, 1 stop bit.
// [R21] Host commands are ASCII, CR LF terminated, space before any parameter.
// [R22] Unrecognised commands are answered with a question mark.
// [R23] Every response, reports included, begins with a space.
// [R24] A streaming or polling selection is written to non-volatile storage.
// [R25] Latest filtered and raw readings are held between measurements.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
module gas_ctrl
	import gas_ctrl_pkg::*;
#(
	parameter int BAUD_DIV_P    = BAUD_DIV,
	parameter int MEAS_PERIOD_P = MEAS_PERIOD,
	parameter int MEAS_BUSY_P   = MEAS_BUSY
)(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_rxd,
	output logic             o_txd,
	input  wire logic [15:0] i_sensor_ppm,
	input  wire logic [1:0]  i_nv_mode,
	output logic [1:0]       o_nv_mode,
	output logic             o_nv_wr,
	output logic             o_ready,
	output logic             o_meas_busy,
	input  wire logic [7:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest
);
	localparam int PW = $clog2(MEAS_PERIOD_P + 1);

	if (MEAS_BUSY_P < 2 || MEAS_BUSY_P >= MEAS_PERIOD_P)
	begin
		$error("bad measurement timing");
	end

	typedef enum logic [1:0] {P_LETTER, P_SEP, P_NUM, P_LF} parse_t;
	typedef enum logic [1:0] {S_IDLE, S_CONV, S_SEND} send_t;

	logic [1:0]        mode_q;
	logic              boot_q;
	logic [PW-1:0]     per_cnt_q;
	logic              meas_done;
	logic [15:0]       sensor_q, raw_q, filt_q, ref_q;
	logic signed [17:0] zero_q;
	logic              have_q;
	logic [2:0]        filt_sel_q;
	parse_t            pst_q;
	logic [7:0]        pcmd_q, ecmd_q;
	logic [16:0]       pval_q, eval_q;
	logic [2:0]        pnd_q;
	logic              pbad_q, phas_q, ebad_q, ehas_q, exec_pend_q, rep_pend_q;
	logic              rx_valid, tx_ready, txv_q;
	logic [7:0]        rx_data, txc_q;
	send_t             sst_q;
	logic [7:0]        s_letter_q;
	logic              s_num_q;
	logic [15:0]       rem_q;
	logic [3:0]        dig_q [5];
	logic [2:0]        ci_q;
	logic [3:0]        idx_q;
	logic              exec_fire, exec_ok, start_rep;
	logic [15:0]       exec_val;

	function automatic logic [15:0] wgt(input logic [2:0] i);
		case (i)
			3'h0: wgt = 16'd10000;
			3'h1: wgt = 16'd1000;
			3'h2: wgt = 16'd100;
			3'h3: wgt = 16'd10;
			default: wgt = 16'd1;
		endcase
	endfunction

	function automatic logic [15:0] sat16(input logic signed [17:0] d);
		if (d < 0)
			sat16 = 16'h0000;
		else if (d > 18'sh0FFFF)
			sat16 = 16'hFFFF;
		else
			sat16 = d[15:0];
	endfunction

	gas_uart #(.DIV(BAUD_DIV_P)) u_link ( // [R20]
		.i_clk      (i_clk),
		.i_rst      (i_rst),
		.i_rxd      (i_rxd),
		.o_txd      (o_txd),
		.o_rx_valid (rx_valid),
		.o_rx_data  (rx_data),
		.i_tx_valid (txv_q),
		.i_tx_data  (txc_q),
		.o_tx_ready (tx_ready)
	);

	// ----------------------------------------------------------------
	// Measurement cadence
	// ----------------------------------------------------------------
	assign meas_done = o_meas_busy && (per_cnt_q == PW'(MEAS_BUSY_P - 1));

	// The busy window is the conversion activity; it starts right after reset.
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			per_cnt_q   <= '0;
			o_meas_busy <= 1'b1; // [R1]
		end
		else if (mode_q == MODE_CMD)
		begin
			per_cnt_q   <= '0; // [R5]
			o_meas_busy <= 1'b0;
		end
		else if (per_cnt_q == PW'(MEAS_PERIOD_P - 1))
		begin
			per_cnt_q   <= '0; // [R2]
			o_meas_busy <= 1'b1;
		end
		else
		begin
			per_cnt_q   <= per_cnt_q + PW'(1);
			o_meas_busy <= (per_cnt_q + PW'(1)) < PW'(MEAS_BUSY_P);
		end
	end

	// A shift of n moves the output 1/2^n of the way per sample, so a larger
	// setting settles more slowly; small steps can stall a few ppm short.
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			sensor_q <= 16'h0000;
			raw_q    <= 16'h0000;
			filt_q   <= 16'h0000;
			have_q   <= 1'b0;
		end
		else if (meas_done)
		begin
			sensor_q <= i_sensor_ppm;
			raw_q    <= sat16($signed({2'b00, i_sensor_ppm}) - zero_q); // [R15] [R25]
			have_q   <= 1'b1;
			if (!have_q)
				filt_q <= sat16($signed({2'b00, i_sensor_ppm}) - zero_q);
			else
				filt_q <= sat16($signed({2'b00, filt_q}) + // [R13] [R14]
					(($signed({2'b00, sat16($signed({2'b00, i_sensor_ppm}) - zero_q)}) -
					$signed({2'b00, filt_q})) >>> filt_sel_q));
		end
	end

	// ----------------------------------------------------------------
	// Command parser
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			pst_q  <= P_LETTER;
			pcmd_q <= 8'h00;
			pval_q <= 17'h00000;
			pnd_q  <= 3'h0;
			pbad_q <= 1'b0;
			phas_q <= 1'b0;
		end
		else if (rx_valid)
		begin
			case (pst_q)
				P_LETTER:
				begin
					pcmd_q <= rx_data;
					pval_q <= 17'h00000;
					pnd_q  <= 3'h0;
					phas_q <= 1'b0;
					pbad_q <= (rx_data == ASC_CR);
					pst_q  <= (rx_data == ASC_CR) ? P_LF : P_SEP;
				end
				P_SEP:
				begin
					phas_q <= (rx_data == ASC_SP);
					pbad_q <= pbad_q || (rx_data != ASC_SP && rx_data != ASC_CR);
					pst_q  <= (rx_data == ASC_CR) ? P_LF : P_NUM;
				end
				P_NUM:
				begin
					if (rx_data == ASC_CR)
					begin
						pbad_q <= pbad_q || (pnd_q == 3'h0);
						pst_q  <= P_LF;
					end
					else if (rx_data >= ASC_ZERO && rx_data <= ASC_ZERO + 8'h09 && pnd_q != 3'h5)
					begin
						pval_q <= 17'(pval_q * 17'd10 + 17'(rx_data - ASC_ZERO));
						pnd_q  <= pnd_q + 3'h1;
					end
					else
						pbad_q <= 1'b1;
				end
				default:
					pst_q <= P_LETTER;
			endcase
		end
	end

	// A complete line is handed over once; a line that ends while the previous
	// one is still pending is dropped, since the link has no flow control.
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			exec_pend_q <= 1'b0;
			ecmd_q      <= 8'h00;
			eval_q      <= 17'h00000;
			ebad_q      <= 1'b0;
			ehas_q      <= 1'b0;
		end
		else if (rx_valid && pst_q == P_LF && !exec_pend_q)
		begin
			exec_pend_q <= 1'b1;
			ecmd_q      <= pcmd_q;
			eval_q      <= pval_q;
			ebad_q      <= pbad_q || (rx_data != ASC_LF) || pval_q > 17'h0FFFF;
			ehas_q      <= phas_q;
		end
		else if (exec_fire)
			exec_pend_q <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Command execution
	// ----------------------------------------------------------------
	assign exec_fire = exec_pend_q && sst_q == S_IDLE &&
		!(mode_q == MODE_STREAM && o_meas_busy); // [R7] [R10]

	always_comb
	begin
		exec_ok  = 1'b0;
		exec_val = eval_q[15:0];
		if (!ebad_q)
		begin
			case (ecmd_q)
				CMD_MODE: exec_ok = ehas_q && eval_q <= 17'd2; // [R4]
				CMD_FILT: exec_ok = ehas_q && eval_q <= 17'(FILT_MAX);
				CMD_RDF:
				begin
					exec_ok  = !ehas_q && mode_q != MODE_CMD; // [R6]
					exec_val = filt_q; // [R3]
				end
				CMD_RDR:
				begin
					exec_ok  = !ehas_q && mode_q != MODE_CMD; // [R6]
					exec_val = raw_q; // [R15]
				end
				CMD_REF: exec_ok = ehas_q && mode_q != MODE_CMD;
				CMD_ZKG:
				begin
					exec_ok  = !ehas_q && mode_q != MODE_CMD;
					exec_val = ref_q;
				end
				CMD_ZN2:
				begin
					exec_ok  = !ehas_q && mode_q != MODE_CMD;
					exec_val = 16'h0000;
				end
				default: exec_ok = 1'b0; // [R22]
			endcase
		end
	end

	// Mode and filter settings; power-up picks up the stored selection once.
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			mode_q     <= MODE_STREAM; // [R1]
			boot_q     <= 1'b1;
			o_ready    <= 1'b0;
			filt_sel_q <= FILT_RST;
			o_nv_wr    <= 1'b0;
			o_nv_mode  <= MODE_STREAM;
		end
		else
		begin
			o_nv_wr <= 1'b0;
			boot_q  <= 1'b0;
			if (boot_q)
			begin
				mode_q  <= (i_nv_mode == MODE_POLL) ? MODE_POLL : MODE_STREAM; // [R8] [R12]
				o_ready <= 1'b1;
			end
			if (exec_fire && exec_ok && ecmd_q == CMD_MODE)
			begin
				mode_q <= eval_q[1:0];
				if (eval_q[1:0] != MODE_CMD)
				begin
					o_nv_wr   <= 1'b1; // [R24]
					o_nv_mode <= eval_q[1:0];
				end
			end
			if (exec_fire && exec_ok && ecmd_q == CMD_FILT)
				filt_sel_q <= eval_q[2:0]; // [R13]
			else if (i_avs_write && !o_avs_waitrequest && i_avs_address == REG_CTRL)
				filt_sel_q <= i_avs_writedata[CTRL_FILT_W-1:0];
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			ref_q  <= REF_RST;
			zero_q <= 18'sh00000;
		end
		else if (exec_fire && exec_ok)
		begin
			if (ecmd_q == CMD_REF)
				ref_q <= eval_q[15:0];
			else if (ecmd_q == CMD_ZKG)
				zero_q <= $signed({2'b00, sensor_q}) - $signed({2'b00, ref_q}); // [R16]
			else if (ecmd_q == CMD_ZN2)
				zero_q <= $signed({2'b00, sensor_q}); // [R16] [R18]
		end
	end

	// ----------------------------------------------------------------
	// Response sender
	// ----------------------------------------------------------------
	assign start_rep = rep_pend_q && sst_q == S_IDLE && !exec_fire;

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			rep_pend_q <= 1'b0;
		else
			rep_pend_q <= (meas_done && mode_q == MODE_STREAM) || // [R9] [R11]
				(rep_pend_q && !start_rep && mode_q == MODE_STREAM);
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			sst_q      <= S_IDLE;
			s_letter_q <= ASC_QM;
			s_num_q    <= 1'b0;
			rem_q      <= 16'h0000;
			ci_q       <= 3'h0;
			idx_q      <= 4'h0;
			txv_q      <= 1'b0;
			txc_q      <= ASC_SP;
			for (int i = 0; i < 5; i++)
				dig_q[i] <= 4'h0;
		end
		else
		begin
			case (sst_q)
				S_IDLE:
				begin
					idx_q <= 4'h0;
					ci_q  <= 3'h0;
					for (int i = 0; i < 5; i++)
						dig_q[i] <= 4'h0;
					if (exec_fire)
					begin
						s_letter_q <= exec_ok ? ecmd_q : ASC_QM; // [R22]
						s_num_q    <= exec_ok;
						rem_q      <= exec_val;
						sst_q      <= S_CONV;
					end
					else if (start_rep)
					begin
						s_letter_q <= CMD_RDF;
						s_num_q    <= 1'b1;
						rem_q      <= filt_q;
						sst_q      <= S_CONV;
					end
				end
				S_CONV:
				begin
					if (rem_q >= wgt(ci_q))
					begin
						rem_q        <= rem_q - wgt(ci_q);
						dig_q[ci_q]  <= dig_q[ci_q] + 4'h1;
					end
					else if (ci_q == 3'h4)
						sst_q <= S_SEND;
					else
						ci_q <= ci_q + 3'h1;
				end
				S_SEND:
				begin
					if (txv_q)
					begin
						if (tx_ready)
						begin
							txv_q <= 1'b0;
							idx_q <= idx_q + 4'h1;
							if (idx_q == (s_num_q ? 4'h9 : 4'h3))
								sst_q <= S_IDLE;
						end
					end
					else if (tx_ready)
					begin
						txv_q <= 1'b1;
						if (idx_q == 4'h0)
							txc_q <= ASC_SP; // [R23]
						else if (idx_q == 4'h1)
							txc_q <= s_letter_q;
						else if (s_num_q && idx_q == 4'h2)
							txc_q <= ASC_SP;
						else if (s_num_q && idx_q <= 4'h7)
							txc_q <= ASC_ZERO + {4'h0, dig_q[3'(idx_q - 4'h3)]};
						else if (idx_q == (s_num_q ? 4'h8 : 4'h2))
							txc_q <= ASC_CR;
						else
							txc_q <= ASC_LF;
					end
				end
				default: sst_q <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Register bus slave: one wait state, then the answer
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata    <= 32'h0000_0000;
		end
		else
		begin
			o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
			if (i_avs_read && o_avs_waitrequest)
			begin
				case (i_avs_address)
					REG_STATUS: o_avs_readdata <= 32'({exec_pend_q, o_meas_busy, o_ready,
						mode_q}) << ST_MODE_LSB;
					REG_FILT:   o_avs_readdata <= {16'h0000, filt_q};
					REG_RAW:    o_avs_readdata <= {16'h0000, raw_q};
					REG_ZERO:   o_avs_readdata <= {{14{zero_q[17]}}, zero_q};
					REG_CTRL:   o_avs_readdata <= {29'h0000_0000, filt_sel_q};
					default:    o_avs_readdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	logic [PW-1:0] gap_q;
	always_ff @(posedge i_clk)
	begin
		if (i_rst || meas_done)
			gap_q <= '0;
		else if (mode_q == MODE_CMD)
			gap_q <= PW'(MEAS_PERIOD_P - MEAS_BUSY_P);
		else
			gap_q <= gap_q + PW'(1);
	end

	chk_cmd_no_meas:  assert property (mode_q == MODE_CMD && $past(mode_q) == MODE_CMD
		|-> !o_meas_busy) else $error("measuring in command mode"); // [R5]
	chk_cmd_refuse:   assert property (exec_fire && mode_q == MODE_CMD && ecmd_q == CMD_ZN2
		|=> s_letter_q == ASC_QM && $stable(zero_q)) else $error("zeroing accepted"); // [R6]
	chk_cmd_no_defer: assert property (exec_pend_q && mode_q == MODE_CMD && sst_q == S_IDLE
		|-> exec_fire) else $error("command deferred in command mode"); // [R7]
	chk_stream_defer: assert property (exec_fire |-> !(mode_q == MODE_STREAM && o_meas_busy))
		else $error("command run during measurement"); // [R10]
	chk_stream_report: assert property (meas_done && mode_q == MODE_STREAM |=> rep_pend_q)
		else $error("stream report missing"); // [R9]
	chk_poll_quiet:   assert property (mode_q == MODE_POLL |=> !rep_pend_q)
		else $error("unsolicited report in polling"); // [R11]
	chk_nv_store:     assert property (exec_fire && exec_ok && ecmd_q == CMD_MODE && eval_q != 0
		|=> o_nv_wr && o_nv_mode == $past(eval_q[1:0])) else $error("mode not stored"); // [R24]
	chk_meas_period:  assert property (meas_done && have_q && $past(mode_q) == mode_q
		&& gap_q != 0 |-> gap_q == PW'(MEAS_PERIOD_P - 1)) else $error("cadence wrong"); // [R2]
	chk_raw_hold:     assert property (!meas_done |=> $stable(raw_q) && $stable(filt_q))
		else $error("reading changed between measurements"); // [R25]
	chk_nitro_zero:   assert property (exec_fire && exec_ok && ecmd_q == CMD_ZN2
		|=> zero_q == $signed({2'b00, $past(sensor_q)})) else $error("nitrogen zero wrong"); // [R18]

	cov_stream_rep:   cover property (start_rep ##1 sst_q == S_CONV);
	cov_poll_read:    cover property (exec_fire && exec_ok && ecmd_q == CMD_RDF && mode_q == MODE_POLL);
	cov_unknown:      cover property (exec_fire && !exec_ok);
	cov_known_gas:    cover property (exec_fire && exec_ok && ecmd_q == CMD_ZKG);

endmodule

// file: gas_host_model.sv
// Host-side serial model: sends command lines and collects reply bytes.
module gas_host_model
#(
	parameter int DIV = 16
)(
	input  wire logic i_clk,
	input  wire logic i_txd,
	output logic      o_rxd
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rx_q[$];
	logic [7:0] sh;
	initial o_rxd = 1'b1;
	// One frame, low bit first, idle high.
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			o_rxd <= fr[i];
			repeat (DIV) @(posedge i_clk);
		end
	endtask
	// Parameters are sent after a space; every line ends in CR LF.
	task automatic send_line(input string s);
		for (int i = 0; i < s.len(); i++)
			send_byte(s[i]);
		send_byte(8'h0D);
		send_byte(8'h0A);
	endtask
	always
	begin
		@(negedge i_txd);
		repeat (DIV / 2) @(posedge i_clk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (DIV) @(posedge i_clk);
			sh[i] = i_txd;
		end
		rx_q.push_back(sh);
		repeat (DIV) @(posedge i_clk);
	end
endmodule

// file: gas_sensor_mode_and_zero_control_bench.sv
// Self-checking bench for the gas sensor controller.
module gas_sensor_mode_and_zero_control_bench import gas_ctrl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        rxd;
	logic        txd;
	logic [15:0] ppm = 16'h0320;
	logic [1:0]  nv = 2'h1;
	logic [1:0]  nv_o;
	logic [1:0]  nv_seen = 2'h0;
	logic        nv_wr;
	logic        busy;
	logic        rdy;
	logic [7:0]  adr = 8'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic        wreq;
	logic [31:0] q;
	int          num_errors = 0;
	int          checks = 0;
	time         t0;
	time         t1;
	always #2.5 clk = ~clk;
	always @(posedge clk) if (nv_wr === 1'b1) nv_seen <= nv_o;
	always @(negedge busy)
	begin
		t0 = t1;
		t1 = $time;
	end
	gas_ctrl #(.BAUD_DIV_P(16), .MEAS_PERIOD_P(8000), .MEAS_BUSY_P(200)) i_gas_ctrl (
		.i_clk(clk), .i_rst(rst), .i_rxd(rxd), .o_txd(txd), .i_sensor_ppm(ppm),
		.i_nv_mode(nv), .o_nv_mode(nv_o), .o_nv_wr(nv_wr), .o_ready(rdy), .o_meas_busy(busy),
		.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wreq));
	gas_host_model #(.DIV(16)) i_gas_host_model (.i_clk(clk), .i_txd(txd), .o_rxd(rxd));
	task automatic results();
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		adr <= a;
		wdat <= d;
		rd <= !w;
		wr <= w;
		do @(posedge clk); while (wreq !== 1'b0 && ++n < 50);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		chk(n < 50, 1);
		@(posedge clk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		chk(q, e);
	endtask
	task automatic expect_line(input string s);
		int n;
		n = 0;
		s = {s, "\015\012"};
		while (i_gas_host_model.rx_q.size() < s.len() && n < 20000)
		begin
			@(posedge clk);
			n++;
		end
		for (int i = 0; i < s.len(); i++)
			chk(32'(i_gas_host_model.rx_q.size() ? i_gas_host_model.rx_q.pop_front() : 8'hXX), 32'(s[i]));
	endtask
	task automatic cmd(input string c, input string r);
		i_gas_host_model.send_line(c);
		expect_line(r);
	endtask
	task automatic boot(input logic [1:0] v, input logic [31:0] m);
		nv <= v;
		rst <= 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		bus(REG_STATUS, 1'b0, 32'h0);
		chk({29'h0, q[2:0]}, m | 32'h4);
	endtask
	initial
	begin
		#400_000;
		num_errors++;
		results();
	end
	initial
	begin
		@(posedge clk);
		boot(2'h1, 32'h1);
		rdc(REG_CTRL, 32'h4);
		rdc(8'h40, 32'h0);
		expect_line(" Z 00800");
		bus(REG_FILT, 1'b1, 32'h0);
		rdc(REG_FILT, 32'h320);
		rdc(REG_RAW, 32'h320);
		ppm <= 16'h0640;
		bus(REG_CTRL, 1'b1, 32'h1);
		rdc(REG_CTRL, 32'h1);
		expect_line(" Z 01200");
		chk(32'(t1 - t0), 32'h9C40);
		$display("streaming test done");
		cmd("K 2", " K 00002");
		chk(nv_seen, 2'h2);
		repeat (8400) @(posedge clk);
		chk(i_gas_host_model.rx_q.size(), 0);
		cmd("z", " z 01600");
		cmd("Z", " Z 01400");
		cmd("Q", " ?");
		cmd("A 1", " A 00001");
		$display("polling test done");
		chk(rdy, 1'b1);
		cmd("U", " U 00000");
		repeat (8000) @(posedge clk);
		cmd("z", " z 00000");
		rdc(REG_ZERO, 32'h640);
		cmd("X 400", " X 00400");
		cmd("G", " G 00400");
		rdc(REG_ZERO, 32'h4B0);
		$display("zero test done");
		cmd("K 0", " K 00000");
		cmd("Z", " ?");
		cmd("U", " ?");
		chk(busy, 1'b0);
		$display("command test done");
		boot(2'h0, 32'h1);
		boot(2'h2, 32'h2);
		$display("power cycle test done");
		results();
	end
endmodule
